// *** rtl/prfd_decoder.sv ***
// Purpose: register file decoder with system group and paged top group
// Assumes: core requests are synchronous to core_clk; pages answer reads in the strobe cycle
// Notes:   page reads take one extra cycle, shown by req_busy
`default_nettype none
`include "prfd_regs.svh"
module prfd_decoder #(
    parameter int          PAGES      = `PRFD_PAGE_MAX,
    parameter logic [63:0] PAGE_FITTED = `PRFD_PAGE_FITTED
) (
    input  wire logic                core_clk,
    input  wire logic                reset,
    input  wire logic                ce,
    input  wire logic                req,
    input  wire logic                req_wr,
    input  wire prfd_pkg::prfd_mode_t req_mode,
    input  wire logic [7:0]          req_addr,
    input  wire logic [7:0]          req_wdata,
    output logic                     req_busy,
    output logic [7:0]               rd_data,
    output logic                     rd_valid,
    output logic                     page_wr,
    output logic                     page_rd,
    output logic [5:0]               page_num,
    output logic [3:0]               page_reg,
    output logic [7:0]               page_wdata,
    input  wire logic [7:0]          page_rdata,
    output logic [47:0]              port_data,
    output logic [7:0]               working_group_pointer,
    output logic [7:0]               peripheral_page_select
);
    if (PAGES < 1 || PAGES > `PRFD_PAGE_MAX) begin : g_pages_check
        $error("PAGES must lie between 1 and 64");
    end

    prfd_pkg::prfd_state_t q;
    prfd_pkg::prfd_state_t d;

    // effective address; only 8 bits exist, no memory space is ever reached
    function automatic logic [7:0] eff_addr(input prfd_pkg::prfd_mode_t m,
                                            input logic [7:0] a,
                                            input logic [7:0] wgp);
        case (m)
            prfd_pkg::PRFD_WORKING:  eff_addr = {wgp[7:4], a[3:0]};
            prfd_pkg::PRFD_SYSTEM:   eff_addr = {`PRFD_SYS_GROUP, a[3:0]};
            prfd_pkg::PRFD_INDIRECT: eff_addr = a;
            default:                 eff_addr = a;
        endcase
    endfunction

    function automatic logic page_ok(input logic [7:0] pps);
        page_ok = (int'(pps[5:0]) < PAGES) && PAGE_FITTED[pps[5:0]];
    endfunction

    logic [7:0] ea;
    logic [3:0] grp;
    logic [3:0] idx;
    logic       acc;

    assign ea  = eff_addr(req_mode, req_addr, q.sys[`PRFD_WGP_IDX]);
    assign grp = ea[7:4];
    assign idx = ea[3:0];
    assign acc = req && !q.busy;

    always_comb begin
        d        = q;
        d.rvalid = 1'b0;
        d.pg_wr  = 1'b0;
        d.pg_rd  = 1'b0;
        if (q.pg_rd) begin
            d.rdata  = page_rdata;
            d.rvalid = 1'b1;
            d.busy   = 1'b0;
        end
        if (acc) begin
            case (grp)
                `PRFD_SYS_GROUP: begin
                    if (req_wr) begin
                        d.sys[idx] = req_wdata;
                    end else begin
                        d.rdata  = q.sys[idx];
                        d.rvalid = 1'b1;
                    end
                end
                `PRFD_PAGE_GROUP: begin
                    if (page_ok(q.sys[`PRFD_PPS_IDX])) begin
                        d.pg_num   = q.sys[`PRFD_PPS_IDX][5:0];
                        d.pg_reg   = idx;
                        d.pg_wdata = req_wdata;
                        d.pg_wr    = req_wr;
                        d.pg_rd    = !req_wr;
                        d.busy     = !req_wr;
                    end else if (!req_wr) begin
                        // absent page reads as zero so software can probe
                        d.rdata  = 8'h00;
                        d.rvalid = 1'b1;
                    end
                end
                default: begin
                    if (req_wr) begin
                        d.gp[ea] = req_wdata;
                    end else begin
                        d.rdata  = q.gp[ea];
                        d.rvalid = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign req_busy               = q.busy;
    assign rd_data                = q.rdata;
    assign rd_valid               = q.rvalid;
    assign page_wr                = q.pg_wr;
    assign page_rd                = q.pg_rd;
    assign page_num               = q.pg_num;
    assign page_reg               = q.pg_reg;
    assign page_wdata             = q.pg_wdata;
    assign working_group_pointer  = q.sys[`PRFD_WGP_IDX];
    assign peripheral_page_select = q.sys[`PRFD_PPS_IDX];
    // port data registers are the lowest six system registers
    assign port_data = {q.sys[5], q.sys[4], q.sys[3], q.sys[2], q.sys[1], q.sys[0]};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    logic local_acc;
    assign local_acc = acc && ce && grp != `PRFD_PAGE_GROUP;

    sequence page_read_issue;
        acc && ce && !req_wr && grp == `PRFD_PAGE_GROUP && page_ok(q.sys[`PRFD_PPS_IDX]);
    endsequence

    sequence page_read_done;
        ce && q.pg_rd ##1 q.rvalid && q.rdata == $past(page_rdata);
    endsequence

    gp_write_store_a: assert property (
        local_acc && req_wr && ea <= `PRFD_GP_LAST |=> q.gp[$past(ea)] == $past(req_wdata))
        else $error("storage write lost");

    sys_group_read_a: assert property (
        local_acc && !req_wr && grp == `PRFD_SYS_GROUP
        |=> q.rvalid && q.rdata == $past(q.sys[idx]))
        else $error("system group read wrong");

    page_strobe_a: assert property (
        acc && ce && req_wr && grp == `PRFD_PAGE_GROUP && page_ok(q.sys[`PRFD_PPS_IDX])
        |=> page_wr && page_reg == $past(idx) && page_wdata == $past(req_wdata))
        else $error("page write strobe wrong");

    page_select_hold_a: assert property (
        ce && !(acc && req_wr && ea == `PRFD_PPS_ADDR) |=> $stable(peripheral_page_select))
        else $error("page select changed without write");

    working_addr_a: assert property (
        req_mode == prfd_pkg::PRFD_WORKING |-> ea == {working_group_pointer[7:4], req_addr[3:0]})
        else $error("working address wrong");

    system_nibble_a: assert property (
        req_mode == prfd_pkg::PRFD_SYSTEM |-> grp == `PRFD_SYS_GROUP)
        else $error("system mode left group E");

    absent_page_a: assert property (
        acc && ce && grp == `PRFD_PAGE_GROUP && !page_ok(q.sys[`PRFD_PPS_IDX])
        |=> !page_wr && !page_rd && !req_busy)
        else $error("absent page was strobed");

    page_read_path_a: assert property (
        page_read_issue ##1 ce |-> page_read_done)
        else $error("page read not returned");

    port_data_a: assert property (
        local_acc && req_wr && grp == `PRFD_SYS_GROUP && idx < `PRFD_PORT_COUNT
        |=> port_data[8 * $past(idx) +: 8] == $past(req_wdata))
        else $error("port data register not updated");

    gp_read_a: assert property (
        local_acc && !req_wr && grp < `PRFD_SYS_GROUP
        |=> q.rvalid && q.rdata == $past(q.gp[ea]))
        else $error("storage read wrong");

    sys_write_a: assert property (
        local_acc && req_wr && grp == `PRFD_SYS_GROUP
        |=> q.sys[$past(idx)] == $past(req_wdata))
        else $error("system group write lost");

    page_read_busy_a: assert property (
        page_read_issue |=> page_rd && req_busy && page_reg == $past(idx))
        else $error("page read strobe wrong");

    page_select_write_a: assert property (
        local_acc && req_wr && ea == `PRFD_PPS_ADDR
        |=> peripheral_page_select == $past(req_wdata))
        else $error("page select write lost");

    // system mode must land in group E whatever the address byte holds
    system_read_a: assert property (
        acc && ce && !req_wr && req_mode == prfd_pkg::PRFD_SYSTEM
        |=> q.rvalid && q.rdata == $past(q.sys[req_addr[3:0]]))
        else $error("system mode read wrong");

    // the busy cycle is a hole in the request stream, nothing may be taken
    busy_refuse_a: assert property (
        req_busy && ce |=> !page_wr && !page_rd && $stable(q.gp) && $stable(q.sys))
        else $error("request taken while busy");

    ce_freeze_a: assert property (
        !ce |=> $stable(q))
        else $error("state moved with clock enable low");
endmodule
`default_nettype wire

// *** rtl/prfd_pkg.sv ***
// Purpose: types of the paged register file decoder
// Assumes: nothing beyond the address map header
// Notes:   no constants live here, only types
`default_nettype none
package prfd_pkg;
    typedef enum logic [1:0] {
        PRFD_DIRECT   = 2'b00,
        PRFD_WORKING  = 2'b01,
        PRFD_SYSTEM   = 2'b10,
        PRFD_INDIRECT = 2'b11
    } prfd_mode_t;

    typedef struct packed {
        logic [223:0][7:0] gp;
        logic [15:0][7:0]  sys;
        logic [7:0]        rdata;
        logic              rvalid;
        logic              busy;
        logic              pg_wr;
        logic              pg_rd;
        logic [5:0]        pg_num;
        logic [3:0]        pg_reg;
        logic [7:0]        pg_wdata;
    } prfd_state_t;
endpackage
`default_nettype wire

// *** rtl/prfd_regs.svh ***
// Purpose: address map and reset values of the paged register file decoder
// Assumes: 8-bit register addressing bus
// Notes:   definitions only
`ifndef PRFD_REGS_SVH
`define PRFD_REGS_SVH
`define PRFD_GP_COUNT      224
`define PRFD_GP_LAST       8'hDF
`define PRFD_SYS_GROUP     4'hE
`define PRFD_PAGE_GROUP    4'hF
`define PRFD_WGP_ADDR      8'hE9
`define PRFD_PPS_ADDR      8'hEA
`define PRFD_WGP_IDX       4'h9
`define PRFD_PPS_IDX       4'hA
`define PRFD_PORT_COUNT    6
`define PRFD_PAGE_MAX      64
`define PRFD_PAGE_FITTED   64'h8000_0000_0100_070D
`define PRFD_REG_RESET     8'h00
`endif

// *** test/prfd_page_model.sv ***
// Purpose: behavioural peripheral pages behind the paged top group
// Assumes: read data is wanted in the strobe cycle
// Notes:   every page answers; fitting is the decoder's business
`default_nettype none
module prfd_page_model (
    input  wire logic       core_clk,
    input  wire logic       page_wr,
    input  wire logic       page_rd,
    input  wire logic [5:0] page_num,
    input  wire logic [3:0] page_reg,
    input  wire logic [7:0] page_wdata,
    output logic [7:0]      page_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:1023];
    logic [7:0] last_q = 8'h00;
    // 64 pages of 16 bytes
    always @(posedge core_clk) begin
        if (page_wr) begin
            mem[{page_num, page_reg}] <= page_wdata;
        end
        if (page_rd) begin
            last_q <= page_rdata;
        end
    end
    // released bus shows the inverse of the last value, not a stale copy
    assign page_rdata = page_rd ? mem[{page_num, page_reg}] : ~last_q;
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: self-checking bench of the paged register file decoder
// Assumes: inputs change at the falling edge of core_clk
// Notes:   each scenario is one task
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 core_clk  = 1'b0;
    logic                 reset     = 1'b1;
    logic                 ce        = 1'b1;
    logic                 req       = 1'b0;
    logic                 req_wr    = 1'b0;
    prfd_pkg::prfd_mode_t req_mode  = prfd_pkg::PRFD_DIRECT;
    logic [7:0]           req_addr  = 8'h00;
    logic [7:0]           req_wdata = 8'h00;
    wire logic            req_busy, rd_valid, page_wr, page_rd;
    wire logic [7:0]      rd_data, page_wdata, page_rdata, wgp, pps;
    wire logic [5:0]      page_num;
    wire logic [3:0]      page_reg;
    wire logic [47:0]     port_data;
    int                   n_mismatch = 0;
    int                   checked = 0;
    int                   cycles = 0;
    logic [7:0]           q;
    logic                 pw;
    logic                 bz;
    int                   lat;

    prfd_decoder prfd_decoder_inst (.core_clk(core_clk), .reset(reset), .ce(ce), .req(req),
        .req_wr(req_wr), .req_mode(req_mode), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_busy(req_busy), .rd_data(rd_data), .rd_valid(rd_valid), .page_wr(page_wr),
        .page_rd(page_rd), .page_num(page_num), .page_reg(page_reg), .page_wdata(page_wdata),
        .page_rdata(page_rdata), .port_data(port_data), .working_group_pointer(wgp),
        .peripheral_page_select(pps));
    prfd_page_model prfd_page_model_inst (.core_clk(core_clk), .page_wr(page_wr),
        .page_rd(page_rd), .page_num(page_num), .page_reg(page_reg),
        .page_wdata(page_wdata), .page_rdata(page_rdata));

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    task automatic final_report();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one request; a read waits a bounded time for its answer
    task automatic op(input logic w, input prfd_pkg::prfd_mode_t m, input logic [7:0] a, d);
        @(negedge core_clk);
        req = 1'b1;
        req_wr = w;
        req_mode = m;
        req_addr = a;
        req_wdata = d;
        @(negedge core_clk);
        req = 1'b0;
        pw = page_wr;
        bz = req_busy;
        lat = 0;
        while (!w && rd_valid !== 1'b1 && lat < 3) begin
            @(negedge core_clk);
            lat++;
        end
        q = rd_data;
    endtask

    task automatic t_gp();
        op(1'b1, prfd_pkg::PRFD_DIRECT, 8'h00, 8'hA5);
        op(1'b1, prfd_pkg::PRFD_INDIRECT, 8'hDF, 8'h5A);
        op(1'b0, prfd_pkg::PRFD_DIRECT, 8'h00, 8'h00);
        chk(64'({bz, lat[7:0], q}), 64'h00A5);
        op(1'b0, prfd_pkg::PRFD_DIRECT, 8'hDF, 8'h00);
        chk(64'({bz, lat[7:0], q}), 64'h005A);
    endtask

    task automatic t_sys();
        for (int n = 0; n < 6; n++) begin
            op(1'b1, prfd_pkg::PRFD_DIRECT, 8'hE0 + 8'(n), 8'h10 + 8'(n));
        end
        chk(64'(port_data), 64'h1514_1312_1110);
        op(1'b0, prfd_pkg::PRFD_DIRECT, 8'hE3, 8'h00);
        chk(64'(q), 64'h13);
        op(1'b0, prfd_pkg::PRFD_DIRECT, 8'hDF, 8'h00);
        chk(64'(q), 64'h5A);
    endtask

    task automatic t_work();
        op(1'b1, prfd_pkg::PRFD_DIRECT, 8'hE9, 8'h30);
        chk(64'(wgp), 64'h30);
        op(1'b1, prfd_pkg::PRFD_WORKING, 8'hF5, 8'h77);
        op(1'b0, prfd_pkg::PRFD_DIRECT, 8'h35, 8'h00);
        chk(64'(q), 64'h77);
        op(1'b0, prfd_pkg::PRFD_SYSTEM, 8'h79, 8'h00);
        chk(64'(q), 64'h30);
        op(1'b1, prfd_pkg::PRFD_SYSTEM, 8'h09, 8'hE4);
        op(1'b0, prfd_pkg::PRFD_WORKING, 8'h09, 8'h00);
        chk(64'(q), 64'hE4);
        op(1'b0, prfd_pkg::PRFD_INDIRECT, 8'hE9, 8'h00);
        chk(64'(q), 64'hE4);
    endtask

    task automatic t_page();
        op(1'b1, prfd_pkg::PRFD_SYSTEM, 8'h0A, 8'h02);
        chk(64'(pps), 64'h02);
        op(1'b1, prfd_pkg::PRFD_DIRECT, 8'hF3, 8'hC3);
        chk(64'({pw, page_num, page_reg, page_wdata}), 64'h4_23C3);
        for (int k = 0; k < 2; k++) begin
            op(1'b0, prfd_pkg::PRFD_DIRECT, 8'hF3, 8'h00);
            chk(64'({bz, lat[7:0], q}), 64'h1_01C3);
        end
        op(1'b1, prfd_pkg::PRFD_DIRECT, 8'hEA, 8'h03);
        op(1'b1, prfd_pkg::PRFD_DIRECT, 8'hF3, 8'h3C);
        op(1'b0, prfd_pkg::PRFD_DIRECT, 8'hF3, 8'h00);
        chk(64'(q), 64'h3C);
        // upper select bits are kept but do not steer the page
        op(1'b1, prfd_pkg::PRFD_DIRECT, 8'hEA, 8'hC2);
        op(1'b0, prfd_pkg::PRFD_DIRECT, 8'hF3, 8'h00);
        chk(64'(q), 64'hC3);
        op(1'b1, prfd_pkg::PRFD_DIRECT, 8'hEA, 8'h3F);
        op(1'b1, prfd_pkg::PRFD_DIRECT, 8'hF0, 8'hE7);
        op(1'b0, prfd_pkg::PRFD_DIRECT, 8'hF0, 8'h00);
        chk(64'({bz, lat[7:0], q}), 64'h1_01E7);
        op(1'b1, prfd_pkg::PRFD_DIRECT, 8'hEA, 8'h01);
        op(1'b1, prfd_pkg::PRFD_DIRECT, 8'hF3, 8'h99);
        chk(64'(pw), 64'h0);
        op(1'b0, prfd_pkg::PRFD_DIRECT, 8'hF3, 8'h00);
        chk(64'({bz, lat[7:0], q}), 64'h0);
    endtask

    // a request in the busy cycle of a page read must be ignored
    task automatic t_busy();
        op(1'b1, prfd_pkg::PRFD_DIRECT, 8'h10, 8'h11);
        op(1'b1, prfd_pkg::PRFD_DIRECT, 8'hEA, 8'h02);
        @(negedge core_clk);
        req = 1'b1;
        req_wr = 1'b0;
        req_mode = prfd_pkg::PRFD_DIRECT;
        req_addr = 8'hF3;
        @(negedge core_clk);
        chk(64'(req_busy), 64'h1);
        req_wr = 1'b1;
        req_addr = 8'h10;
        req_wdata = 8'hEE;
        @(negedge core_clk);
        req = 1'b0;
        chk(64'({rd_valid, rd_data}), 64'h1C3);
        op(1'b0, prfd_pkg::PRFD_DIRECT, 8'h10, 8'h00);
        chk(64'(q), 64'h11);
    endtask

    // with the clock enable low nothing may change, a write included
    task automatic t_ce();
        @(negedge core_clk);
        ce = 1'b0;
        req = 1'b1;
        req_wr = 1'b1;
        req_mode = prfd_pkg::PRFD_DIRECT;
        req_addr = 8'h20;
        req_wdata = 8'h42;
        repeat (2) @(negedge core_clk);
        ce = 1'b1;
        req = 1'b0;
        op(1'b0, prfd_pkg::PRFD_DIRECT, 8'h20, 8'h00);
        chk(64'(q), 64'h0);
    endtask

    // a mid-run reset clears storage and both pointers
    task automatic t_reset();
        @(negedge core_clk);
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        chk(64'({wgp, pps, port_data}), 64'h0);
        op(1'b0, prfd_pkg::PRFD_DIRECT, 8'h00, 8'h00);
        chk(64'(q), 64'h0);
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        repeat (12) @(negedge core_clk);
        reset = 1'b0;
        t_gp();
        t_sys();
        t_work();
        t_page();
        t_busy();
        t_ce();
        t_reset();
        final_report();
    end
endmodule
`default_nettype wire
